// >>> verilog/css_pkg.sv
// shared constants and types for the clock source safeguard block
package css_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing, 200 MHz system clock
    localparam int CLK_PERIOD_PS = 5000;
    // shortest accepted oscillator half period; shorter pulses count as spikes
    localparam int SPIKE_NS = 40;
    localparam int SPIKE_CYC = (SPIKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // shortest internal clock period under the safeguard (frequency cap)
    localparam int CAP_NS = 125;
    localparam int CAP_CYC = (CAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest gap between main oscillator edges before one counts as missing
    localparam int MISS_NS = 1000;
    localparam int MISS_CYC = (MISS_NS * 1000) / CLK_PERIOD_PS;
    // backup oscillator period
    localparam int BACKUP_NS = 2000;
    localparam int BACKUP_CYC = (BACKUP_NS * 1000) / CLK_PERIOD_PS;
    // good main edges seen before the main oscillator counts as started
    localparam int START_EDGES = 16;
    // internal clock dividers
    localparam int PERIPH_DIV = 12;
    localparam int CORE_DIV = 13;
    // machine cycles per instruction
    localparam logic [2:0] INSTR_LEN_2 = 3'h2;
    localparam logic [2:0] INSTR_LEN_4 = 3'h4;
    localparam logic [2:0] INSTR_LEN_5 = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // register map: printed offsets are word indices, byte address is four times
    localparam logic [7:0] CONV_CTRL_IDX = 8'hd1;
    localparam logic [11:0] CONV_CTRL_ADDR = 12'h344;
    localparam logic [11:0] CLK_STATUS_ADDR = 12'h400;
    localparam int OSC_STOP_BIT = 2;
    localparam logic OSC_STOP_RST = 1'b0;
    localparam int STAT_BACKUP_BIT = 0;
    localparam int STAT_HANDOVER_BIT = 1;
    localparam int STAT_MAIN_OK_BIT = 2;
    localparam int STAT_SAFEGUARD_BIT = 3;
    localparam int STAT_RC_BIT = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        CSS_MAIN = 2'h0,
        CSS_BACKUP = 2'h1,
        CSS_HANDOVER = 2'h3
    } css_state_t;

    typedef struct packed {
        logic int_tick;
        logic periph_tick;
        logic core_tick;
        logic instr_end;
    } css_ticks_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } css_wb_req_t;

endpackage

// >>> verilog/css_clock_safeguard.sv
// clock source selection, safeguard filter, backup failover and clock dividers
// Notes on behaviour
// - peripheral tick is internal clock over 12, core tick internal clock over 13
// - instructions last two, four or five machine cycles (core ticks)
// - strap selects crystal/resonator or resistor main oscillator type
// - with safeguard, stop bit halts main oscillator and backup takes over
// - clearing stop bit or reset turns the main oscillator back on
// - return to main waits start-up plus end of current instruction on backup
// - backup exists only with safeguard; starts one period after a missing edge
// - on backup the core runs unchanged, only at the slower rate
// - after reset backup clocks everything until main oscillator runs
// - backup switches off at the first instruction end after main oscillator is running
// - converter control bit 2 stops main oscillator when one, only with the safeguard fitted
// - other converter control bits have no function here, read zero
// - safeguard strap off disables filtering, capping and the backup
// - safeguard filters spikes and caps the internal clock rate
// - over-frequency input cycles are dropped to stay below the cap
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module css_clock_safeguard (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire css_pkg::css_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // mask option straps, caught during reset
    input wire logic strap_safeguard_i,
    input wire logic strap_rc_osc_i,
    // oscillator pins and core handshake
    input wire logic osc_main_i,
    input wire logic [2:0] instr_len_i,
    output logic osc_main_en_o,
    output logic osc_rc_mode_o,
    output logic backup_osc_en_o,
    // derived clock ticks
    output css_pkg::css_ticks_t ticks_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // straps and control register
    logic safeguard_q;
    logic rc_mode_q;
    logic main_osc_stop_q;
    logic main_osc_stop_d;

    // straps are sampled while reset is held so they are stable from release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            safeguard_q <= strap_safeguard_i;
            rc_mode_q <= strap_rc_osc_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone decode
    wire wb_req = wb_req_i.cyc & wb_req_i.stb;
    wire hit_ctrl = wb_req_i.adr == css_pkg::CONV_CTRL_ADDR;
    wire hit_stat = wb_req_i.adr == css_pkg::CLK_STATUS_ADDR;
    wire ctrl_wr = wb_req & wb_ack_o & wb_req_i.we & hit_ctrl & wb_req_i.sel[0];
    wire wb_ack_d = wb_req & ~wb_ack_o;

    // stop bit only matters with the safeguard fitted, a reset always clears it
    assign main_osc_stop_d = ctrl_wr ? wb_req_i.dat[css_pkg::OSC_STOP_BIT] : main_osc_stop_q;

    ////////////////////////////////////////////////////////////////////////////////
    // main oscillator spike filter
    logic osc_lvl_q;
    logic [7:0] spike_cnt_q;
    logic [7:0] spike_cnt_d;
    logic osc_lvl_d;
    wire osc_live = osc_main_en_o;
    wire osc_in = osc_live & osc_main_i;
    wire osc_differs = osc_in != osc_lvl_q;
    wire spike_done = spike_cnt_q >= 8'(css_pkg::SPIKE_CYC - 1);

    // with the safeguard a level must persist before it is believed
    assign osc_lvl_d = !safeguard_q ? osc_in :
                       (osc_differs & spike_done) ? osc_in : osc_lvl_q;
    assign spike_cnt_d = (!osc_differs || spike_done) ? 8'h00 : spike_cnt_q + 8'h01;

    wire main_rise = osc_lvl_d & ~osc_lvl_q;

    ////////////////////////////////////////////////////////////////////////////////
    // edge supervision and source state
    css_pkg::css_state_t state_q;
    css_pkg::css_state_t state_d;
    logic [9:0] miss_cnt_q;
    logic [9:0] gap_cnt_q;
    logic [9:0] bk_cnt_q;
    logic [4:0] start_cnt_q;
    logic [9:0] miss_cnt_d;
    logic [9:0] gap_cnt_d;
    logic [9:0] bk_cnt_d;
    logic [4:0] start_cnt_d;

    wire missing = miss_cnt_q >= 10'(css_pkg::MISS_CYC);
    wire main_ok = start_cnt_q == 5'(css_pkg::START_EDGES);
    wire lost_main = safeguard_q & (missing | main_osc_stop_q);
    wire gap_ok = !safeguard_q || gap_cnt_q >= 10'(css_pkg::CAP_CYC - 1);
    wire on_backup = state_q != css_pkg::CSS_MAIN;
    wire bk_wrap = bk_cnt_q == 10'(css_pkg::BACKUP_CYC - 1);
    wire instr_end;

    assign miss_cnt_d = main_rise ? 10'h000 : (missing ? miss_cnt_q : miss_cnt_q + 10'h001);
    // a running main oscillator is counted good edge by edge, reset on a missing edge or the stop bit
    assign start_cnt_d = (missing | main_osc_stop_q) ? 5'h00 :
                         (main_rise & !main_ok) ? start_cnt_q + 5'h01 : start_cnt_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            css_pkg::CSS_MAIN: begin
                if (lost_main) begin
                    state_d = css_pkg::CSS_BACKUP;
                end
            end
            css_pkg::CSS_BACKUP: begin
                if (main_ok) begin
                    state_d = css_pkg::CSS_HANDOVER;
                end
            end
            css_pkg::CSS_HANDOVER: begin
                if (!main_ok) begin
                    state_d = css_pkg::CSS_BACKUP;
                end else if (instr_end) begin
                    state_d = css_pkg::CSS_MAIN;
                end
            end
            default: begin
                state_d = css_pkg::CSS_BACKUP;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // internal clock tick
    wire main_tick = main_rise & gap_ok;
    // backup divider restarts on entry, so its first tick is a full period late
    wire bk_tick = bk_wrap & gap_ok;
    wire int_tick = on_backup ? bk_tick : main_tick;

    assign bk_cnt_d = (!on_backup || bk_wrap) ? 10'h000 : bk_cnt_q + 10'h001;
    assign gap_cnt_d = int_tick ? 10'h000 :
                       (gap_cnt_q == 10'h3ff) ? gap_cnt_q : gap_cnt_q + 10'h001;

    ////////////////////////////////////////////////////////////////////////////////
    // dividers and machine cycle accounting
    logic [3:0] per_cnt_q;
    logic [3:0] core_cnt_q;
    logic [2:0] mc_cnt_q;
    logic [2:0] mc_len_q;
    logic [3:0] per_cnt_d;
    logic [3:0] core_cnt_d;
    logic [2:0] mc_cnt_d;
    logic [2:0] mc_len_d;

    wire per_wrap = int_tick & (per_cnt_q == 4'(css_pkg::PERIPH_DIV - 1));
    wire core_wrap = int_tick & (core_cnt_q == 4'(css_pkg::CORE_DIV - 1));
    wire len_ok = instr_len_i == css_pkg::INSTR_LEN_2 || instr_len_i == css_pkg::INSTR_LEN_4
                  || instr_len_i == css_pkg::INSTR_LEN_5;
    wire [2:0] next_len = len_ok ? instr_len_i : css_pkg::INSTR_LEN_2;

    assign per_cnt_d = !int_tick ? per_cnt_q : (per_wrap ? 4'h0 : per_cnt_q + 4'h1);
    assign core_cnt_d = !int_tick ? core_cnt_q : (core_wrap ? 4'h0 : core_cnt_q + 4'h1);
    assign instr_end = core_wrap & (mc_cnt_q == mc_len_q - 3'h1);
    assign mc_cnt_d = !core_wrap ? mc_cnt_q : (instr_end ? 3'h0 : mc_cnt_q + 3'h1);
    // length is taken at each instruction boundary
    assign mc_len_d = instr_end ? next_len : mc_len_q;

    ////////////////////////////////////////////////////////////////////////////////
    // read data
    wire [31:0] stat_word = {27'h0000000, rc_mode_q, safeguard_q, main_ok,
                             state_q == css_pkg::CSS_HANDOVER, on_backup};
    wire [31:0] ctrl_word = 32'(main_osc_stop_q) << css_pkg::OSC_STOP_BIT;
    wire [31:0] rd_word = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h00000000);

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_osc_stop_q <= css_pkg::OSC_STOP_RST;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            osc_lvl_q <= 1'b0;
            spike_cnt_q <= 8'h00;
            state_q <= css_pkg::CSS_BACKUP;
            miss_cnt_q <= 10'h000;
            gap_cnt_q <= 10'h000;
            bk_cnt_q <= 10'h000;
            start_cnt_q <= 5'h00;
            per_cnt_q <= 4'h0;
            core_cnt_q <= 4'h0;
            mc_cnt_q <= 3'h0;
            mc_len_q <= css_pkg::INSTR_LEN_2;
        end else begin
            main_osc_stop_q <= main_osc_stop_d;
            wb_ack_o <= wb_ack_d;
            wb_dat_o <= wb_ack_d ? rd_word : 32'h00000000;
            osc_lvl_q <= osc_lvl_d;
            spike_cnt_q <= spike_cnt_d;
            // without the safeguard there is no backup source at all
            state_q <= safeguard_q ? state_d : css_pkg::CSS_MAIN;
            miss_cnt_q <= miss_cnt_d;
            gap_cnt_q <= gap_cnt_d;
            bk_cnt_q <= bk_cnt_d;
            start_cnt_q <= start_cnt_d;
            per_cnt_q <= per_cnt_d;
            core_cnt_q <= core_cnt_d;
            mc_cnt_q <= mc_cnt_d;
            mc_len_q <= mc_len_d;
        end
    end

    // output flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_main_en_o <= 1'b1;
            osc_rc_mode_o <= 1'b0;
            backup_osc_en_o <= 1'b0;
            ticks_o <= '0;
        end else begin
            osc_main_en_o <= !(safeguard_q & main_osc_stop_d);
            osc_rc_mode_o <= rc_mode_q;
            backup_osc_en_o <= safeguard_q & (state_d != css_pkg::CSS_MAIN);
            ticks_o.int_tick <= int_tick;
            ticks_o.periph_tick <= per_wrap;
            ticks_o.core_tick <= core_wrap;
            ticks_o.instr_end <= instr_end;
        end
    end

endmodule

// >>> bench/css_clock_safeguard_properties.sv
// port-level assertions for the clock source safeguard
`timescale 1ns/1ps
module css_clock_safeguard_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire css_pkg::css_wb_req_t wb_req_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic strap_safeguard_i,
    input wire logic osc_main_en_o,
    input wire logic backup_osc_en_o,
    input wire css_pkg::css_ticks_t ticks_o
);
    logic [11:0] gap_q;
    logic [3:0] pc_q;
    logic [3:0] cc_q;
    wire ctl_w = wb_ack_o && wb_req_i.adr == css_pkg::CONV_CTRL_ADDR;
    wire wr_w = ctl_w && wb_req_i.we && wb_req_i.sel[0];
    // gap saturates so the first tick after reset never looks early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_q <= 12'hfff;
            pc_q <= 4'h0;
            cc_q <= 4'h0;
        end else begin
            gap_q <= ticks_o.int_tick ? 12'h1 : gap_q + {11'h0, gap_q != 12'hfff};
            pc_q <= ticks_o.periph_tick ? 4'h0 : pc_q + {3'h0, ticks_o.int_tick};
            cc_q <= ticks_o.core_tick ? 4'h0 : cc_q + {3'h0, ticks_o.int_tick};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=>
        wb_ack_o ##1 !wb_ack_o) else $error("ack is not a one cycle answer");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    ctrl_unused_a: assert property (ctl_w && !wb_req_i.we |-> wb_dat_o[31:3] == 29'h0 &&
        wb_dat_o[1:0] == 2'h0) else $error("unused control bits read nonzero");
    stop_halt_a: assert property (wr_w && wb_req_i.dat[2] && strap_safeguard_i |->
        ##[1:3] (!osc_main_en_o && backup_osc_en_o)) else $error("stop bit did not hand over");
    restart_a: assert property (wr_w && !wb_req_i.dat[2] |-> ##[1:3] osc_main_en_o)
        else $error("main oscillator not restarted");
    reset_main_a: assert property ($fell(rst_i) |-> osc_main_en_o)
        else $error("main oscillator off after reset");
    no_guard_a: assert property (!strap_safeguard_i |-> osc_main_en_o && !backup_osc_en_o)
        else $error("backup active without safeguard");
    tick_cap_a: assert property (ticks_o.int_tick && strap_safeguard_i |-> gap_q >= 12'h019)
        else $error("internal clock above cap");
    periph_div_a: assert property (ticks_o.periph_tick |-> ticks_o.int_tick && pc_q == 4'hb)
        else $error("peripheral divide wrong");
    core_div_a: assert property (ticks_o.core_tick |-> ticks_o.int_tick && cc_q == 4'hc)
        else $error("core divide wrong");
    instr_core_a: assert property (ticks_o.instr_end |-> ticks_o.core_tick)
        else $error("instruction end off a core tick");
endmodule
bind css_clock_safeguard css_clock_safeguard_properties i_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .strap_safeguard_i(strap_safeguard_i), .osc_main_en_o(osc_main_en_o),
    .backup_osc_en_o(backup_osc_en_o), .ticks_o(ticks_o));

// >>> bench/css_clock_safeguard_tb.sv
// self-checking bench for the clock source safeguard
`timescale 1ns/1ps
module css_clock_safeguard_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    css_pkg::css_wb_req_t req = '0;
    logic [31:0] dat, rd;
    logic ack, sg = 1'b1, rc = 1'b1, osc = 1'b0, main_en, rc_mode, bk_en;
    logic [2:0] len = 3'h2;
    css_pkg::css_ticks_t ticks;
    int errors = 0, checks = 0, half = 0, ph = 0, g, k;
    always #2.5 clk_i = ~clk_i;
    // main oscillator model, half period in system cycles, zero holds its current level
    always @(posedge clk_i) begin
        ph <= (half == 0 || ph >= half - 1) ? 0 : ph + 1;
        if (half != 0 && ph >= half - 1)
            osc <= ~osc;
    end
    css_clock_safeguard i_css_clock_safeguard (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
        .wb_dat_o(dat), .wb_ack_o(ack), .strap_safeguard_i(sg), .strap_rc_osc_i(rc),
        .osc_main_i(osc), .instr_len_i(len), .osc_main_en_o(main_en),
        .osc_rc_mode_o(rc_mode), .backup_osc_en_o(bk_en), .ticks_o(ticks));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            chk(1'b0, "wait ran out");
            finish_test();
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, 4'hf, a, d};
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1)
                break;
        end
        rd = dat;
        req <= '0;
        bound(n, 50);
    endtask
    // cycles between two events on one tick bit
    task automatic gap(input int b);
        int n;
        for (n = 0; n < 30000 && ticks[b] !== 1'b1; n++)
            @(posedge clk_i);
        @(posedge clk_i);
        for (g = 1; g < 30000 && ticks[b] !== 1'b1; g++)
            @(posedge clk_i);
        bound(g, 30000);
    endtask
    task automatic wait_bk(input logic v, input int lim);
        int n;
        for (n = 0; n < lim && bk_en !== v; n++)
            @(posedge clk_i);
        bound(n, lim);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_boot();
        chk(main_en === 1'b1, "enable after reset");
        wb(1'b0, css_pkg::CONV_CTRL_ADDR, 32'h0);
        chk(rd === 32'h0, "control reset");
        // the strap copy only appears one edge after release
        chk(rc_mode === 1'b1, "rc strap");
        wb(1'b0, css_pkg::CLK_STATUS_ADDR, 32'h0);
        chk(rd[4:0] === 5'h19, "boot status");
        gap(3);
        chk(g === 400, "backup period");
        $display("boot done");
    endtask
    task automatic t_start();
        half = 20;
        wait_bk(1'b0, 30000);
        wb(1'b0, css_pkg::CLK_STATUS_ADDR, 32'h0);
        chk(rd[2:0] === 3'h4, "main status");
        gap(3);
        chk(g === 40, "main tick");
        gap(2);
        gap(2);
        chk(g === 480, "peripheral tick");
        gap(1);
        gap(1);
        chk(g === 520, "core tick");
        for (k = 2; k <= 5; k++) begin
            if (k != 3) begin
                len <= k[2:0];
                gap(0);
                gap(0);
                chk(g === k * 520, "instruction length");
            end
        end
        len <= 3'h2;
        $display("start done");
    endtask
    task automatic t_fast();
        half = 10;
        gap(3);
        gap(3);
        chk(g === 40, "capped tick");
        half = 5;
        wait_bk(1'b1, 1000);
        half = 20;
        wait_bk(1'b0, 30000);
        $display("fast done");
    endtask
    task automatic t_stop();
        wb(1'b1, css_pkg::CONV_CTRL_ADDR, 32'hffffffff);
        repeat (3) @(posedge clk_i);
        chk(main_en === 1'b0 && bk_en === 1'b1, "stop handover");
        wb(1'b0, css_pkg::CONV_CTRL_ADDR, 32'h0);
        chk(rd === 32'h4, "control readback");
        wb(1'b0, 12'h7fc, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        gap(3);
        chk(g === 400, "backup period");
        wb(1'b1, css_pkg::CONV_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(main_en === 1'b1, "restart");
        wait_bk(1'b0, 30000);
        wb(1'b1, css_pkg::CONV_CTRL_ADDR, 32'h4);
        $display("stop done");
    endtask
    task automatic t_nosg();
        rst_i <= 1'b1;
        sg <= 1'b0;
        rc <= 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, css_pkg::CONV_CTRL_ADDR, 32'h0);
        chk(rd === 32'h0 && main_en === 1'b1, "reset restart");
        chk(rc_mode === 1'b0, "crystal strap");
        wb(1'b1, css_pkg::CONV_CTRL_ADDR, 32'h4);
        repeat (3) @(posedge clk_i);
        chk(main_en === 1'b1 && bk_en === 1'b0, "no safeguard");
        half = 10;
        gap(3);
        gap(3);
        chk(g === 20, "uncapped tick");
        $display("no safeguard done");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_start();
        t_fast();
        t_stop();
        t_nosg();
        finish_test();
    end
endmodule
